// File: design/bst_tap.sv
// boundary-scan test access port with instruction decode and data registers
// Behaviour
// [R1] code 0000 drives pins from boundary cells; chain between test in and out
// [R2] code 1111 puts the one-bit bypass stage in the serial path
// [R3] code 0010 loads the 32-bit identification register and shifts it
// [R4] code 0011 uses bypass and forces every output driver high-impedance
// [R5] code 0001 captures current pin values into boundary cells for shifting
// [R6] code 0001 shifts test data into cells without driving pins
// [R7] controller loads only the five defined codes; others reserved (the code loads any 4-bit code and decodes reserved ones as bypass)
// [R8] identification bit 0 always reads one
// [R9] identification bits 31:28 hold the revision number
// [R10] identification bits 27:12 hold a fixed part number
// [R11] identification bits 11:1 hold the manufacturer code
// [R12] output forcing and sampling covers all outputs except test data out
// [R13] input sampling covers all inputs except test in, mode select, test reset
// [R14] four-bit instruction register loads serially in Shift-IR
// [R15] mode select and test input sampled on rising test clock
// [R16] test out changes on falling test clock; high-impedance when not shifting
// [R17] chain bit 0 shifts out first; enable cells active high
// [R18] test reset low returns to Test-Logic-Reset with identification selected
`timescale 1ns/100ps
module bst_tap (
  // system
  input wire logic clk_i,
  input wire logic arst_n_i,
  // test port pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // core side pins
  input wire logic [bst_pkg::BC_N-1:0] core_in_i,
  input wire logic [bst_pkg::BC_N-1:0] core_out_i,
  input wire logic [bst_pkg::BC_N-1:0] core_oe_i,
  output logic [bst_pkg::BC_N-1:0] pin_out_o,
  output logic [bst_pkg::BC_N-1:0] pin_oe_o,
  // status
  output logic [3:0] ir_o,
  output logic test_mode_o
);
  localparam int N = bst_pkg::BC_N;
  // chain layout: inputs, then output values, then output enables
  localparam int CH = 3 * N;

  // synchronised test port pins
  logic [3:0] sync_q;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_n_s;
  logic tck_d_ff;

  // controller state and registers
  bst_pkg::bst_state_t st_ff;
  bst_pkg::bst_state_t nxt_st;
  logic [3:0] ir_sh_ff;
  logic [3:0] ir_ff;
  logic by_ff;
  logic [bst_pkg::ID_W-1:0] id_ff;
  logic [CH-1:0] bc_ff;
  logic [CH-1:0] bc_upd_ff;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic [N-1:0] pin_out_ff;
  logic [N-1:0] pin_oe_ff;
  logic test_mode_ff;

  // decode
  wire logic tck_rise;
  wire logic tck_fall;
  wire logic sel_chain;
  wire logic sel_id;
  wire logic sel_by;
  wire logic in_cap_dr;
  wire logic in_sh_dr;
  wire logic in_upd_dr;
  wire logic in_cap_ir;
  wire logic in_sh_ir;
  wire logic in_upd_ir;
  wire logic dr_lsb;
  wire logic [bst_pkg::ID_W-1:0] id_word;
  wire logic [CH-1:0] bc_snap;
  wire logic [N-1:0] drv_out;
  wire logic [N-1:0] drv_oe;

  // tdi, tms and trst are not boundary cells
  bst_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({tck_i, tms_i, tdi_i, trst_n_i}),
    .q_o(sync_q)
  ); // R13
  assign {tck_s, tms_s, tdi_s, trst_n_s} = sync_q;

  // test clock edges as seen by clk_i; both idle low after reset
  assign tck_rise = tck_s & ~tck_d_ff; // R15
  assign tck_fall = ~tck_s & tck_d_ff; // R16

  function automatic logic is_chain(input logic [3:0] op);
    is_chain = (op == bst_pkg::OP_EXTEST) || (op == bst_pkg::OP_SAMPLE);
  endfunction : is_chain

  // reserved codes fall back to the bypass stage
  function automatic logic is_bypass(input logic [3:0] op);
    is_bypass = !is_chain(op) && (op != bst_pkg::OP_IDCODE);
  endfunction : is_bypass

  function automatic bst_pkg::bst_state_t step(input bst_pkg::bst_state_t s, input logic m);
    unique case (s)
      bst_pkg::ST_RESET: step = m ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE: step = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: step = m ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: step = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR: step = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: step = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
      bst_pkg::ST_PA_DR: step = m ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
      bst_pkg::ST_EX2_DR: step = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: step = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: step = m ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: step = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR: step = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: step = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
      bst_pkg::ST_PA_IR: step = m ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
      bst_pkg::ST_EX2_IR: step = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: step = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
    endcase
  endfunction : step

  assign nxt_st = step(st_ff, tms_s); // R15
  assign sel_chain = is_chain(ir_ff); // R1 R5
  assign sel_by = is_bypass(ir_ff); // R2 R4
  assign sel_id = ir_ff == bst_pkg::OP_IDCODE; // R3
  assign in_cap_dr = st_ff == bst_pkg::ST_CAP_DR;
  assign in_sh_dr = st_ff == bst_pkg::ST_SH_DR;
  assign in_upd_dr = st_ff == bst_pkg::ST_UPD_DR;
  assign in_cap_ir = st_ff == bst_pkg::ST_CAP_IR;
  assign in_sh_ir = st_ff == bst_pkg::ST_SH_IR;
  assign in_upd_ir = st_ff == bst_pkg::ST_UPD_IR;
  assign id_word = {bst_pkg::ID_VER, bst_pkg::ID_PART, bst_pkg::ID_MFR, bst_pkg::ID_MARK}; // R8
  assign bc_snap = {core_oe_i, core_out_i, core_in_i}; // R5 R12 R13
  assign dr_lsb = sel_chain ? bc_ff[0] : (sel_id ? id_ff[0] : by_ff); // R17

  // pins follow the core unless a test instruction owns them
  assign drv_out = (ir_ff == bst_pkg::OP_EXTEST) ? bc_upd_ff[2*N-1:N] : core_out_i; // R1 R6 R12
  assign drv_oe = (ir_ff == bst_pkg::OP_HIGHZ) ? '0 :
    ((ir_ff == bst_pkg::OP_EXTEST) ? bc_upd_ff[CH-1:2*N] : core_oe_i); // R4 R17

  // controller state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tck_d_ff <= 1'b0;
      st_ff <= bst_pkg::ST_RESET;
    end else begin
      tck_d_ff <= tck_s;
      if (!trst_n_s) begin
        st_ff <= bst_pkg::ST_RESET; // R18
      end else if (tck_rise) begin
        st_ff <= nxt_st; // R15
      end
    end
  end

  // instruction register: shift on rise, take effect on the update fall
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ir_sh_ff <= '0;
      ir_ff <= bst_pkg::IR_RST_VAL;
    end else begin
      if (!trst_n_s || st_ff == bst_pkg::ST_RESET) begin
        ir_ff <= bst_pkg::IR_RST_VAL; // R18
      end else if (tck_fall && in_upd_ir) begin
        ir_ff <= ir_sh_ff; // R14
      end
      if (tck_rise && in_cap_ir) begin
        ir_sh_ff <= {2'h0, bst_pkg::IR_CAPTURE}; // R14
      end else if (tck_rise && in_sh_ir) begin
        ir_sh_ff <= {tdi_s, ir_sh_ff[3:1]}; // R14
      end
    end
  end

  // data registers: capture and shift on the rising test clock
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      by_ff <= 1'b0;
      id_ff <= '0;
      bc_ff <= '0;
    end else if (tck_rise && in_cap_dr) begin
      by_ff <= 1'b0; // R2
      if (sel_id) begin
        id_ff <= id_word; // R3 R9 R10 R11
      end
      if (sel_chain) begin
        bc_ff <= bc_snap; // R5
      end
    end else if (tck_rise && in_sh_dr) begin
      by_ff <= tdi_s; // R2 R4
      if (sel_id) begin
        id_ff <= {tdi_s, id_ff[bst_pkg::ID_W-1:1]}; // R3
      end
      if (sel_chain) begin
        bc_ff <= {tdi_s, bc_ff[CH-1:1]}; // R6 R17
      end
    end
  end

  // update stage keeps pins steady while the chain shifts
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bc_upd_ff <= '0;
    end else if (tck_fall && in_upd_dr && sel_chain) begin
      bc_upd_ff <= bc_ff; // R1 R6
    end
  end

  // serial output changes on the falling test clock
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_ff <= in_sh_ir ? ir_sh_ff[0] : dr_lsb; // R16 R17
      tdo_oe_ff <= in_sh_ir || in_sh_dr; // R16
    end
  end

  // registered pin drive
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      test_mode_ff <= 1'b0;
    end else begin
      pin_out_ff <= drv_out; // R1 R6
      pin_oe_ff <= drv_oe; // R4
      test_mode_ff <= (ir_ff == bst_pkg::OP_EXTEST) || (ir_ff == bst_pkg::OP_HIGHZ);
    end
  end

  assign tdo_o = tdo_ff;
  assign tdo_oe_o = tdo_oe_ff;
  assign pin_out_o = pin_out_ff;
  assign pin_oe_o = pin_oe_ff;
  assign ir_o = ir_ff;
  assign test_mode_o = test_mode_ff;

  // capture steps
  sequence s_cap_dr;
    tck_rise && in_cap_dr;
  endsequence

  sequence s_cap_ir;
    tck_rise && in_cap_ir;
  endsequence

  chk_ir_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R14
    s_cap_ir |=> ir_sh_ff[1:0] == bst_pkg::IR_CAPTURE)
    else $error("instruction capture pattern wrong");

  chk_id_mark: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R8
    s_cap_dr ##0 sel_id |=> id_ff[0] == 1'b1)
    else $error("identification marker bit not set");

  chk_id_fields: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R9 R10 R11
    s_cap_dr ##0 sel_id |=> id_ff[bst_pkg::ID_VER_LSB +: 4] == bst_pkg::ID_VER &&
      id_ff[bst_pkg::ID_PART_LSB +: 16] == bst_pkg::ID_PART &&
      id_ff[bst_pkg::ID_MFR_LSB +: 11] == bst_pkg::ID_MFR)
    else $error("identification fields wrong");

  chk_bypass_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
    s_cap_dr ##0 sel_by |=> !by_ff)
    else $error("bypass stage did not capture zero");

  chk_highz_pins: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R4
    ir_ff == bst_pkg::OP_HIGHZ |=> pin_oe_o == '0)
    else $error("output enable active under high-impedance code");

  chk_tdo_release: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R16
    tck_fall |=> tdo_oe_o == $past(in_sh_ir || in_sh_dr))
    else $error("serial output enable out of step with shifting");

  chk_trst_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R18
    !trst_n_s |=> st_ff == bst_pkg::ST_RESET && ir_ff == bst_pkg::IR_RST_VAL)
    else $error("test reset did not restore identification");

  chk_sample_keep: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R6
    ir_ff == bst_pkg::OP_SAMPLE |=> pin_out_o == $past(core_out_i))
    else $error("sample code disturbed the output pins");
endmodule : bst_tap

// File: design/bst_pkg.sv
// constants for the boundary-scan test port
package bst_pkg;
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int BC_N = 8;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h2;
  localparam logic [3:0] OP_HIGHZ = 4'h3;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  localparam logic [3:0] IR_RST_VAL = OP_IDCODE;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  // identity fields: values are arbitrary
  localparam logic [3:0] ID_VER = 4'h1;
  localparam logic [15:0] ID_PART = 16'h5a5a;
  localparam logic [10:0] ID_MFR = 11'h2b5;
  localparam logic ID_MARK = 1'b1;
  localparam real TCK_MIN_PERIOD_NS = 100.0;
  localparam real CLK_PERIOD_NS = 8.0;
  localparam int TCK_MIN_CYC = int'((TCK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1.0) / CLK_PERIOD_NS);
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
    ST_SH_DR = 4'h6, ST_EX1_DR = 4'h7, ST_PA_DR = 4'h5, ST_EX2_DR = 4'h4,
    ST_UPD_DR = 4'hc, ST_SEL_IR = 4'hd, ST_CAP_IR = 4'hf, ST_SH_IR = 4'he,
    ST_EX1_IR = 4'ha, ST_PA_IR = 4'hb, ST_EX2_IR = 4'h9, ST_UPD_IR = 4'h8
  } bst_state_t;
endpackage : bst_pkg

// File: design/bst_sync.sv
// two-flop synchroniser for a bundle of pins
`timescale 1ns/100ps
module bst_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= '0;
      q_o <= '0;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule : bst_sync

// File: testbench/bst_ctl.sv
// scan controller model driving the test port
`timescale 1ns/100ps
module bst_ctl (
  // scan pins
  output logic tck_o = 1'b0,
  output logic tms_o = 1'b1,
  output logic tdi_o = 1'b1,
  input wire logic tdo_i
);
  // tms and tdi move in the low half, stable at the rising edge
  task automatic bit_io(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #38 q = tdo_i;
    #2 tck_o = 1'b1;
    #40 tck_o = 1'b0;
  endtask : bit_io
  // only defined codes are ever loaded by the callers
  task automatic scan(input logic ir, input int n, input logic [31:0] d,
    output logic [31:0] q);
    logic b;
    q = '0;
    // park in idle first; this also leaves test-logic-reset
    bit_io(1'b0, 1'b0, b);
    bit_io(1'b1, 1'b0, b);
    if (ir) bit_io(1'b1, 1'b0, b);
    bit_io(1'b0, 1'b0, b);
    bit_io(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) bit_io(i == n - 1, d[i], q[i]);
    bit_io(1'b1, 1'b0, b);
    bit_io(1'b0, 1'b1, b);
  endtask : scan
endmodule : bst_ctl

// File: testbench/tb_bst_tap.sv
// testbench for the boundary-scan test port
`timescale 1ns/100ps
module tb_bst_tap;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic trst_n = 1'b1;
  logic [bst_pkg::BC_N-1:0] cin, cout, coe, pout, poe;
  logic tck, tms, tdi, tdo, tdo_oe, tm;
  logic [3:0] ir;
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
  logic [31:0] q, d;
  int error_cnt = 0;
  int n_checks = 0;
  always #4 clk_i = ~clk_i;
  bst_tap DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .core_in_i(cin), .core_out_i(cout),
    .core_oe_i(coe), .pin_out_o(pout), .pin_oe_o(poe), .ir_o(ir), .test_mode_o(tm));
  bst_ctl u_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_oe ? tdo : 1'b1));
  function automatic logic [31:0] id_exp();
    return {bst_pkg::ID_VER, bst_pkg::ID_PART, bst_pkg::ID_MFR, bst_pkg::ID_MARK};
  endfunction : id_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    q = $urandom(73);
    {cin, cout, coe} = '0;
    repeat (20) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'(tdo_oe), 32'h0);
    u_ctl.scan(1'b0, 32, $urandom, q);
    chk(q, id_exp());
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      #1 {cin, cout, coe} = 24'({$urandom, $urandom});
      d = $urandom;
      u_ctl.scan(1'b1, 4, 32'(codes[k]), q);
      chk(32'(q[1:0]), 32'(bst_pkg::IR_CAPTURE));
      chk(32'(ir), 32'(codes[k]));
      u_ctl.scan(1'b0, codes[k][1] ? 8 : 3 * bst_pkg::BC_N, d, q);
      chk(32'(tm), 32'(codes[k] == 4'h0 || codes[k] == bst_pkg::OP_HIGHZ));
      if (codes[k] == bst_pkg::OP_EXTEST) chk(32'({poe, pout}), 32'(d[23:8]));
      if (codes[k] == bst_pkg::OP_SAMPLE) chk(q, 32'({coe, cout, cin}));
      if (codes[k][1:0] == 2'h3) chk(q, {24'h0, d[6:0], 1'b0});
      if (codes[k] == bst_pkg::OP_HIGHZ) chk(32'(poe), 32'h0);
      if (codes[k] == bst_pkg::OP_SAMPLE) chk(32'(pout), 32'(cout));
    end
    #1 trst_n = 1'b0;
    #60 trst_n = 1'b1;
    repeat (10) @(posedge clk_i);
    chk(32'(ir), 32'(bst_pkg::OP_IDCODE));
    conclude();
  end
endmodule : tb_bst_tap
